// *** shared/gated_event_counter_cfg.svh ***
`ifndef GATED_EVENT_COUNTER_CFG_SVH
`define GATED_EVENT_COUNTER_CFG_SVH

// ********************************
// Register map
// ********************************
`define GEC_ADDR_W 8
`define GEC_CH_STRIDE 8'h10
`define GEC_OFS_CTRL 4'h0
`define GEC_OFS_TBDIV 4'h4
`define GEC_OFS_CMD 4'h8
`define GEC_OFS_COUNT 4'hc
`define GEC_OFS_SELECT 8'h20
`define GEC_OFS_GCMD 8'h24

// ********************************
// Field positions
// ********************************
`define GEC_CTRL_MODE_LSB 0
`define GEC_CTRL_MODE_MSB 2
`define GEC_CTRL_EDGE_BIT 4
`define GEC_STAT_WAIT_BIT 8
`define GEC_STAT_RUN_BIT 9
`define GEC_STAT_OPEN_BIT 10
`define GEC_STAT_OVF_BIT 11
`define GEC_STAT_BAD_BIT 12
`define GEC_CMD_START_BIT 0
`define GEC_CMD_STOP_BIT 1
`define GEC_CMD_CLEAR_BIT 2

// ********************************
// Reset values and limits
// ********************************
`define GEC_MODE_RST 3'h0
`define GEC_MODE_MAX 3'h4
`define GEC_EDGE_RST 1'h0
`define GEC_SELECT_RST 2'h3
`define GEC_SYNC_DEPTH 3

`endif

// *** shared/gec_pkg.sv ***
package gec_pkg;

  // ********************************
  // Gate modes
  // ********************************
  typedef enum logic [2:0] {
    GATE_SOFT = 3'h0,
    GATE_HIGH = 3'h1,
    GATE_LOW = 3'h2,
    GATE_RISE = 3'h3,
    GATE_FALL = 3'h4
  } gate_mode_t;

  // ********************************
  // Channel states
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } chan_state_t;

endpackage : gec_pkg

// *** shared/pin_lvl_if.sv ***
interface pin_lvl_if #(
  parameter int W = 4
);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  modport filt (input raw, output lvl);
  modport user (output raw, input lvl);
endinterface : pin_lvl_if

// *** rtl/pin_filter.sv ***
`include "gated_event_counter_cfg.svh"

module pin_filter #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pin levels
  pin_lvl_if.filt pins
);
  import gec_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } filt_state_t;

  filt_state_t s_r;
  filt_state_t s_nxt;

  // ********************************
  // Three-stage sampling
  // ********************************
  // A level is taken only once stages two and three agree, so a single
  // metastable sample never reaches the edge detectors
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pins.raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.lvl = (s_r.lvl & (s_r.s2 ^ s_r.s3)) | (s_r.s3 & ~(s_r.s2 ^ s_r.s3));
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.lvl = s_r.lvl;

endmodule : pin_filter

// *** rtl/gated_event_counter.sv ***
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "gated_event_counter_cfg.svh"

// What this block does
// RL1: One or two counters, each selectable and started independently, count external events.
// RL2: One high-going or low-going source transition is one counted event.
// RL3: Gate mode 0 ignores the gate; counting starts at the start command.
// RL4: Gate mode 1 counts only while the gate is high after start.
// RL5: Gate mode 2 counts only while the gate is low after start.
// RL6: Gate mode 3 waits for a rising gate edge after start, then counts.
// RL7: Gate mode 4 waits for a falling gate edge after start, then counts.
// RL8: Edge setting 0 counts low-to-high, setting 1 counts high-to-low transitions.
// RL9: A nonzero timebase setting counts internal timebase cycles instead of the source.
// RL10: A zero timebase setting, the default, counts the external source input.
// RL11: Each qualified edge adds exactly one; a closed gate holds the count.
// RL12: Source and gate levels must each stand at least two clock cycles.
module gated_event_counter #(
  parameter int NCH = 2,
  parameter int COUNT_W = 32,
  parameter int TB_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [`GEC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Counter pins
  input wire logic [NCH-1:0] event_source_input,
  input wire logic [NCH-1:0] count_gate_input
);
  import gec_pkg::*;

  // ********************************
  // Parameter checks
  // ********************************
  if (NCH < 1 || NCH > 2) begin : g_bad_nch
    $error("NCH must be 1 or 2");
  end
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
    $error("COUNT_W must lie in 1..32");
  end
  if (TB_W < 1 || TB_W > 32) begin : g_bad_tb_w
    $error("TB_W must lie in 1..32");
  end

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [NCH-1:0][COUNT_W-1:0] count;
    logic [NCH-1:0][2:0] mode;
    logic [NCH-1:0] edge_sel;
    logic [NCH-1:0][TB_W-1:0] tb_div;
    logic [NCH-1:0][TB_W-1:0] tb_cnt;
    logic [NCH-1:0] tb_lvl;
    logic [NCH-1:0] cnt_prev;
    logic [NCH-1:0] gate_prev;
    chan_state_t [NCH-1:0] state;
    logic [NCH-1:0] ovf;
    logic [NCH-1:0] bad_mode;
    logic [NCH-1:0] sel;
    logic [31:0] rdata;
  } gec_state_t;

  gec_state_t s_r;
  gec_state_t s_nxt;

  // ********************************
  // Pin synchronisers
  // ********************************
  pin_lvl_if #(.W(2 * NCH)) pins ();

  assign pins.raw = {count_gate_input, event_source_input};

  pin_filter #(
    .W(2 * NCH)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .pins(pins.filt)
  );

  logic [NCH-1:0] src_lvl;
  logic [NCH-1:0] gate_lvl;

  assign src_lvl = pins.lvl[NCH-1:0];
  assign gate_lvl = pins.lvl[2*NCH-1:NCH];

  // ********************************
  // Helpers
  // ********************************
  function automatic logic gate_open(input logic [2:0] mode, input logic gate);
    logic open;
    open = 1'b1;
    if (mode == GATE_HIGH) begin
      open = gate; // RL4
    end else if (mode == GATE_LOW) begin
      open = ~gate; // RL5
    end
    return open;
  endfunction : gate_open

  function automatic chan_state_t start_state(input logic [2:0] mode);
    chan_state_t st;
    st = ST_RUN; // RL3
    if (mode == GATE_RISE || mode == GATE_FALL) begin
      st = ST_WAIT;
    end
    return st;
  endfunction : start_state

  // ********************************
  // Address decode
  // ********************************
  logic in_chan;
  logic [1:0] ch_idx;
  logic [3:0] ch_ofs;

  always_comb begin
    ch_idx = reg_addr[5:4];
    ch_ofs = reg_addr[3:0];
    in_chan = (reg_addr < `GEC_OFS_SELECT) && (32'(ch_idx) < NCH);
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    logic cs;
    logic hit;
    logic gedge;
    logic do_start;
    logic do_stop;
    logic do_clear;
    logic [COUNT_W-1:0] base;
    logic [31:0] rd;
    cs = 1'b0;
    hit = 1'b0;
    gedge = 1'b0;
    do_start = 1'b0;
    do_stop = 1'b0;
    do_clear = 1'b0;
    base = '0;
    rd = 32'h0000_0000;
    s_nxt = s_r;

    // Global selection and commands
    if (reg_wr && reg_addr == `GEC_OFS_SELECT) begin
      s_nxt.sel = reg_wdata[NCH-1:0]; // RL1
    end

    for (int i = 0; i < NCH; i++) begin
      do_start = 1'b0;
      do_stop = 1'b0;
      do_clear = 1'b0;

      // Free-running timebase; its level toggles every tb_div clocks
      if (s_r.tb_div[i] != '0) begin
        if (s_r.tb_cnt[i] == TB_W'(s_r.tb_div[i] - 1'b1)) begin
          s_nxt.tb_cnt[i] = '0;
          s_nxt.tb_lvl[i] = ~s_r.tb_lvl[i];
        end else begin
          s_nxt.tb_cnt[i] = TB_W'(s_r.tb_cnt[i] + 1'b1);
        end
      end else begin
        s_nxt.tb_cnt[i] = '0;
        s_nxt.tb_lvl[i] = 1'b0;
      end

      // Counted signal and its edge
      if (s_r.tb_div[i] != '0) begin
        cs = s_r.tb_lvl[i]; // RL9
      end else begin
        cs = src_lvl[i]; // RL10
      end
      s_nxt.cnt_prev[i] = cs;
      if (s_r.edge_sel[i]) begin
        hit = ~cs & s_r.cnt_prev[i]; // RL2 RL8
      end else begin
        hit = cs & ~s_r.cnt_prev[i]; // RL2 RL8
      end

      // Gate edge for triggered start
      s_nxt.gate_prev[i] = gate_lvl[i];
      if (s_r.mode[i] == GATE_RISE) begin
        gedge = gate_lvl[i] & ~s_r.gate_prev[i];
      end else begin
        gedge = ~gate_lvl[i] & s_r.gate_prev[i];
      end

      // Channel registers
      if (reg_wr && in_chan && 32'(ch_idx) == i) begin
        unique case (ch_ofs)
          `GEC_OFS_CTRL: begin
            s_nxt.edge_sel[i] = reg_wdata[`GEC_CTRL_EDGE_BIT];
            // Codes beyond the last mode are refused; the old mode stays
            if (reg_wdata[`GEC_CTRL_MODE_MSB:`GEC_CTRL_MODE_LSB] <= `GEC_MODE_MAX) begin
              s_nxt.mode[i] = reg_wdata[`GEC_CTRL_MODE_MSB:`GEC_CTRL_MODE_LSB];
              s_nxt.bad_mode[i] = 1'b0;
            end else begin
              s_nxt.bad_mode[i] = 1'b1;
            end
          end
          `GEC_OFS_TBDIV: begin
            s_nxt.tb_div[i] = reg_wdata[TB_W-1:0];
            s_nxt.tb_cnt[i] = '0;
          end
          `GEC_OFS_CMD: begin
            do_start = reg_wdata[`GEC_CMD_START_BIT] & s_r.sel[i]; // RL1
            do_stop = reg_wdata[`GEC_CMD_STOP_BIT];
            do_clear = reg_wdata[`GEC_CMD_CLEAR_BIT];
          end
          default: begin
          end
        endcase
      end
      if (reg_wr && reg_addr == `GEC_OFS_GCMD && s_r.sel[i]) begin
        do_start = do_start | reg_wdata[`GEC_CMD_START_BIT]; // RL1
        do_stop = do_stop | reg_wdata[`GEC_CMD_STOP_BIT];
        do_clear = do_clear | reg_wdata[`GEC_CMD_CLEAR_BIT];
      end

      // Counting; a clear in the same cycle as an edge keeps the edge
      base = do_clear ? '0 : s_r.count[i];
      hit = hit & (s_r.state[i] == ST_RUN) & gate_open(s_r.mode[i], gate_lvl[i]);
      s_nxt.count[i] = COUNT_W'(base + COUNT_W'(hit)); // RL11
      s_nxt.ovf[i] = (s_r.ovf[i] & ~do_clear) | (hit & (&base));

      // Run control; stop beats start
      unique case (s_r.state[i])
        ST_IDLE: begin
          if (do_start && !do_stop) begin
            s_nxt.state[i] = start_state(s_r.mode[i]); // RL3
          end
        end
        ST_WAIT: begin
          if (do_stop) begin
            s_nxt.state[i] = ST_IDLE;
          end else if (gedge) begin
            s_nxt.state[i] = ST_RUN; // RL6 RL7
          end
        end
        ST_RUN: begin
          if (do_stop) begin
            s_nxt.state[i] = ST_IDLE;
          end
        end
        default: begin
          s_nxt.state[i] = ST_IDLE;
        end
      endcase
    end

    // Read data stand only in the cycle after the strobe
    if (reg_rd) begin
      if (in_chan) begin
        for (int i = 0; i < NCH; i++) begin
          if (32'(ch_idx) == i) begin
            unique case (ch_ofs)
              `GEC_OFS_CTRL: begin
                rd[`GEC_CTRL_MODE_MSB:`GEC_CTRL_MODE_LSB] = s_r.mode[i];
                rd[`GEC_CTRL_EDGE_BIT] = s_r.edge_sel[i];
                rd[`GEC_STAT_WAIT_BIT] = s_r.state[i] == ST_WAIT;
                rd[`GEC_STAT_RUN_BIT] = s_r.state[i] == ST_RUN;
                rd[`GEC_STAT_OPEN_BIT] = gate_open(s_r.mode[i], gate_lvl[i]);
                rd[`GEC_STAT_OVF_BIT] = s_r.ovf[i];
                rd[`GEC_STAT_BAD_BIT] = s_r.bad_mode[i];
              end
              `GEC_OFS_TBDIV: begin
                rd[TB_W-1:0] = s_r.tb_div[i];
              end
              `GEC_OFS_COUNT: begin
                rd[COUNT_W-1:0] = s_r.count[i];
              end
              default: begin
                rd = 32'h0000_0000;
              end
            endcase
          end
        end
      end else if (reg_addr == `GEC_OFS_SELECT) begin
        rd[NCH-1:0] = s_r.sel;
      end
    end
    s_nxt.rdata = rd;
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        s_r.mode[i] <= `GEC_MODE_RST;
        s_r.edge_sel[i] <= `GEC_EDGE_RST;
        s_r.state[i] <= ST_IDLE;
      end
      s_r.sel <= NCH'(`GEC_SELECT_RST);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;

endmodule : gated_event_counter

// *** bench/gec_pins.sv ***
module gec_pins #(
  parameter int NCH = 2
) (
  // Clock
  input wire logic ref_clk,
  // Pin levels
  output logic [NCH-1:0] src,
  output logic [NCH-1:0] gate
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    src = '0;
    gate = '0;
  end
  // Levels stand 5 clocks, three more than the input filter needs
  task automatic toggle(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      src[ch] <= ~src[ch];
      repeat (4) @(posedge ref_clk);
    end
  endtask : toggle
  task automatic set_gate(input int ch, input logic v);
    @(posedge ref_clk);
    gate[ch] <= v;
    repeat (5) @(posedge ref_clk);
  endtask : set_gate
endmodule : gec_pins

// *** bench/gated_event_counter_sva.sv ***
`include "gated_event_counter_cfg.svh"

module gated_event_counter_sva #(
  parameter int NCH = 2,
  parameter int TB_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [`GEC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Counter pins
  input wire logic [NCH-1:0] event_source_input,
  input wire logic [NCH-1:0] count_gate_input
);
  timeunit 1ns;
  timeprecision 1ns;
  import gec_pkg::*;
  // ****
  // Shadow of channel 0 setup; quiet times of its pins
  // ****
  logic [2:0] mode_r = 3'h0;
  logic edge_r = 1'b0;
  logic bad_r = 1'b0;
  logic tb0_r = 1'b1;
  logic src_r = 1'b0;
  logic [3:0] sq = 4'h0;
  logic [3:0] gl = 4'h0;
  logic [3:0] gh = 4'h0;
  logic ctrl_rd;
  logic cnt_rd;
  assign ctrl_rd = reg_rd && reg_addr == 8'h00;
  assign cnt_rd = reg_rd && reg_addr < 8'h20 && reg_addr[3:0] == 4'hc;
  always_ff @(posedge ref_clk) begin
    src_r <= event_source_input[0];
    sq <= (event_source_input[0] != src_r) ? 4'h0 : sq + 4'(sq != 4'hf);
    gl <= count_gate_input[0] ? 4'h0 : gl + 4'(gl != 4'hf);
    gh <= !count_gate_input[0] ? 4'h0 : gh + 4'(gh != 4'hf);
    if (reset) begin
      mode_r <= 3'h0;
      edge_r <= 1'b0;
      bad_r <= 1'b0;
      tb0_r <= 1'b1;
    end else if (reg_wr && reg_addr == 8'h00) begin
      // An illegal mode leaves the old mode in place; the edge is always taken
      bad_r <= reg_wdata[2:0] > 3'h4;
      edge_r <= reg_wdata[4];
      if (reg_wdata[2:0] <= 3'h4) begin
        mode_r <= reg_wdata[2:0];
      end
    end else if (reg_wr && reg_addr == 8'h04) begin
      tb0_r <= reg_wdata[TB_W-1:0] == '0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****
  // Checks
  // ****
  AST_WO_UNMAPPED_ZERO:
    assert property (reg_rd && (reg_addr inside {8'h08, 8'h18, 8'h24} || reg_addr >= 8'h28)
      |=> reg_rdata == 32'h0000_0000) else $error("write-only or unmapped read not zero");
  AST_CTRL_READBACK:
    assert property (ctrl_rd |=> reg_rdata[2:0] == mode_r && reg_rdata[4] == edge_r)
      else $error("mode or edge readback wrong");
  AST_BAD_MODE_FLAG:
    assert property (ctrl_rd |=> reg_rdata[12] == bad_r) else $error("bad mode flag wrong");
  AST_COUNT_STEP:
    assert property (cnt_rd ##1 (cnt_rd && $stable(reg_addr))
      |=> reg_rdata == $past(reg_rdata) || reg_rdata == $past(reg_rdata) + 32'h0000_0001)
      else $error("count stepped by more than one");
  AST_QUIET_HOLDS:
    assert property (cnt_rd && reg_addr == 8'h0c ##1 (ctrl_rd == 0 && reg_rd && reg_addr == 8'h0c
      && tb0_r && sq > 4'h6) |=> $stable(reg_rdata)) else $error("count moved, source quiet");
  AST_HIGH_GATE_HOLDS:
    assert property (cnt_rd && reg_addr == 8'h0c ##1 (reg_rd && reg_addr == 8'h0c && tb0_r
      && mode_r == GATE_HIGH && gl > 4'h8) |=> $stable(reg_rdata)) else $error("gate low, counted");
  AST_LOW_GATE_HOLDS:
    assert property (cnt_rd && reg_addr == 8'h0c ##1 (reg_rd && reg_addr == 8'h0c && tb0_r
      && mode_r == GATE_LOW && gh > 4'h8) |=> $stable(reg_rdata)) else $error("gate high, counted");
endmodule : gated_event_counter_sva

bind gated_event_counter gated_event_counter_sva #(.NCH(NCH), .TB_W(TB_W)) i_sva (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .event_source_input(event_source_input), .count_gate_input(count_gate_input));

// *** bench/gated_event_counter_tb_top.sv ***
module gated_event_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gec_pkg::*;
  typedef struct {int ch; logic [7:0] ctrl; logic g0; logic g1; logic [31:0] exp;} row_t;
  // Pre phase: rise, fall under g0; post phase: rise, fall, rise under g1
  row_t rows[8] = '{
    '{0, 8'h00, 1'b0, 1'b1, 32'h0000_0003}, '{1, 8'h10, 1'b0, 1'b1, 32'h0000_0002},
    '{0, 8'h01, 1'b1, 1'b0, 32'h0000_0001}, '{0, 8'h02, 1'b0, 1'b1, 32'h0000_0001},
    '{0, 8'h03, 1'b0, 1'b1, 32'h0000_0002}, '{0, 8'h03, 1'b1, 1'b1, 32'h0000_0000},
    '{0, 8'h04, 1'b1, 1'b0, 32'h0000_0002}, '{0, 8'h14, 1'b0, 1'b0, 32'h0000_0000}};
  logic [7:0] ra[4] = '{8'h04, 8'h08, 8'h0c, 8'h20};
  logic [31:0] rv[4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic [31:0] d1;
  logic [31:0] d2;
  logic [1:0] src;
  logic [1:0] gate;
  int n_fail = 0;
  int comparisons = 0;
  always #25 ref_clk = ~ref_clk;
  gated_event_counter i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_source_input(src), .count_gate_input(gate));
  gec_pins #(.NCH(2)) i_pins (.ref_clk(ref_clk), .src(src), .gate(gate));
  // ****
  // Bus and check tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Two reads back to back; each result stands only in the cycle after its strobe
  task automatic rd2(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    #1 d1 = reg_rdata;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d2 = reg_rdata;
  endtask : rd2
  task automatic final_report();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    foreach (ra[i]) begin
      rd2(ra[i]);
      chk(d1, rv[i]);
    end
    foreach (rows[i]) begin
      wr(8'h24, 32'h0000_0006);
      wr(8'(rows[i].ch * 16), {24'h00_0000, rows[i].ctrl});
      i_pins.set_gate(rows[i].ch, rows[i].g0);
      wr(8'(rows[i].ch * 16 + 8), 32'h0000_0001);
      i_pins.toggle(rows[i].ch, 2);
      i_pins.set_gate(rows[i].ch, rows[i].g1);
      i_pins.toggle(rows[i].ch, 3);
      repeat (8) @(posedge ref_clk);
      rd2(8'(rows[i].ch * 16 + 12));
      chk(d1, rows[i].exp);
      chk(d2, rows[i].exp);
      i_pins.toggle(rows[i].ch, 1);
    end
    wr(8'h00, 32'h0000_0017);
    rd2(8'h00);
    chk(d1 & 32'h0000_101f, 32'h0000_1014);
    wr(8'h30, 32'h0000_ffff);
    rd2(8'h30);
    chk(d1, 32'h0000_0000);
    // Timebase of 2: one cycle per 4 clocks; start and stop phase allow some slack
    wr(8'h24, 32'h0000_0006);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0002);
    wr(8'h08, 32'h0000_0001);
    rd2(8'h00);
    chk(d1 & 32'h0000_0300, 32'h0000_0200);
    repeat (35) @(posedge ref_clk);
    wr(8'h08, 32'h0000_0002);
    wr(8'h04, 32'h0000_0000);
    repeat (8) @(posedge ref_clk);
    rd2(8'h0c);
    chk(32'(d1 inside {[32'h0000_0008:32'h0000_000c]}), 32'h0000_0001);
    final_report();
  end
endmodule : gated_event_counter_tb_top
